// ### logic/option_byte_consts.svh
`ifndef OPTION_BYTE_CONSTS_SVH
`define OPTION_BYTE_CONSTS_SVH

// ****************************************************************
// Option byte address, layout and erased value
// ****************************************************************
`define OPT_BYTE_ADDR       16'hFFFF
`define OPT_ERASED          8'hFF
`define OPT_LOCK_BIT        0
`define OPT_INHIBIT_BIT     1
`define OPT_BOOT_BIT        2
`define OPT_NOISE_BIT       3
`define OPT_CYCLE_BIT       5
`define OPT_XTAL_BIT        7
`define OPT_FORCED_ONES     8'h50

// ****************************************************************
// Boot vectors
// ****************************************************************
`define BOOT_APP_ADDR       16'h0000
`define BOOT_LOADER_ADDR    16'h3800

// ****************************************************************
// Timing: times in their own unit, counts derived from the clock
// ****************************************************************
`define MCLK_PERIOD_NS      50
`define CYCLES_PER_US       (1000 / `MCLK_PERIOD_NS)
`define PROGRAM_PULSE_US    300
`define ERASE_TIME_US       500
`define READ_TIME_US        1
`define PROGRAM_CYCLES      (`PROGRAM_PULSE_US * `CYCLES_PER_US)
`define ERASE_CYCLES        (`ERASE_TIME_US * `CYCLES_PER_US)
`define READ_CYCLES         (`READ_TIME_US * `CYCLES_PER_US)

`endif

// ### logic/option_byte_pkg.sv
package option_byte_pkg;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    // Programmer pins, all asynchronous to mclk
    typedef struct packed {
        logic        flashMode;
        logic        extReset;
        logic        rd;
        logic        wr;
        logic        erase;
        logic [15:0] addr;
        logic [7:0]  data;
    } prog_pins_t;

    // Settings handed to the processor core
    typedef struct packed {
        logic [15:0] bootAddr;
        logic        noiseReductionEn;
        logic        sixClockMachineCycle;
        logic        crystalLowSpeed;
        logic        codeReadInhibit;
        logic        lockActive;
    } core_cfg_t;

    typedef enum logic [1:0] {
        ST_LOAD,
        ST_RUN,
        ST_FLASH
    } ctl_state_t;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_OPT_RD,
        OP_OPT_WR,
        OP_ARR_RD,
        OP_ARR_WR,
        OP_ERASE
    } flash_op_t;

endpackage : option_byte_pkg

// ### logic/flash_op_timer.sv
`timescale 1ns/10ps
`include "option_byte_consts.svh"

module flash_op_timer #(
    parameter int TW = 16
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          clkEn,
    input  wire logic          start,
    input  wire logic [TW-1:0] loadCount,
    output logic               busy,
    output logic               done
);
    import option_byte_pkg::*;

    typedef struct packed {
        logic [TW-1:0] remain;
        logic          busy;
        logic          done;
    } timer_state_t;

    timer_state_t s_reg;
    timer_state_t s_next;

    // ****************************************************************
    // Down counter; a start while busy is ignored by the caller
    // ****************************************************************
    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        if (start) begin
            s_next.remain = loadCount;
            s_next.busy   = 1'b1;
        end else if (s_reg.busy) begin
            if (s_reg.remain <= TW'(1)) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end else begin
                s_next.remain = s_reg.remain - TW'(1);
            end
        end
    end

    // Frozen while clkEn is low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else if (clkEn) begin
            s_reg <= s_next;
        end
    end

    assign busy = s_reg.busy;
    assign done = s_reg.done;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [TW-1:0] elapsed;
    logic [TW-1:0] loaded;

    // Helper: busy cycles since start, against the loaded count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            elapsed <= '0;
            loaded  <= '0;
        end else if (clkEn) begin
            if (start) begin
                elapsed <= '0;
                loaded  <= loadCount;
            end else if (s_reg.busy) begin
                elapsed <= elapsed + TW'(1);
            end
        end
    end

    chk_timer_length: assert property (@(posedge mclk iff clkEn) disable iff (rst)
        done && loaded > TW'(1) |-> elapsed == loaded)
        else $error("flash operation time differs from loaded count");

endmodule : flash_op_timer

// ### logic/option_byte_security_boot.sv
// What this block does
// - Option byte reachable only in flash mode.
// - Top flash address selects the option byte.
// - Programmed zero bits stick until erase-all or reset.
// - Cleared lock bit blocks all external access except erase-all.
// - Inhibit keeps external table reads off internal.
// - Internal table reads unrestricted; inhibit off frees all.
// - Boot from application or loader flash base.
// - Noise reduction enabled when its bit zero.
// - Cycle bit zero gives six-clock machine cycle.
// - Flash operations timed by the operation timer.
`timescale 1ns/10ps
`include "option_byte_consts.svh"

module option_byte_security_boot #(
    parameter int TW             = 16,
    parameter int PROGRAM_CYCLES = `PROGRAM_CYCLES,
    parameter int ERASE_CYCLES   = `ERASE_CYCLES
) (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic                        clkEn,
    input  wire option_byte_pkg::prog_pins_t progPins,
    input  wire logic [7:0]                  arrayRdData,
    input  wire logic                        codeReadReq,
    input  wire logic                        codeReadFromInternal,
    input  wire logic                        codeReadTargetInternal,
    output option_byte_pkg::core_cfg_t       coreCfg,
    output logic                             coreHold,
    output logic [7:0]                       progDataOut,
    output logic                             progDataOe,
    output logic                             accessRefused,
    output logic                             flashBusy,
    output logic                             arrayReq,
    output logic                             arrayWe,
    output logic                             arrayErase,
    output logic [15:0]                      arrayAddr,
    output logic [7:0]                       arrayData,
    output logic                             codeReadGrant,
    output logic                             codeReadBlocked
);
    import option_byte_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (TW < 8 || TW > 30) begin : g_tw_bad
        $error("timer width out of range");
    end
    if (PROGRAM_CYCLES >= (1 << TW) || ERASE_CYCLES >= (1 << TW) || PROGRAM_CYCLES < 1
        || ERASE_CYCLES < 1) begin : g_cnt_bad
        $error("operation counts do not fit the timer");
    end

    typedef struct packed {
        prog_pins_t  sync1;
        prog_pins_t  sync2;
        logic        rdD;
        logic        wrD;
        logic        erD;
        ctl_state_t  st;
        flash_op_t   pendOp;
        logic [7:0]  pendData;
        logic [7:0]  optStore;
        logic [7:0]  optLatch;
        core_cfg_t   cfg;
        logic        coreHold;
        logic [7:0]  dataOut;
        logic        dataOe;
        logic        refused;
        logic        arrayReq;
        logic        arrayWe;
        logic        arrayErase;
        logic [15:0] arrayAddr;
        logic [7:0]  arrayData;
        logic        codeReadGrant;
        logic        codeReadBlocked;
    } main_state_t;

    main_state_t   s_reg;
    main_state_t   s_next;
    logic          tmrStart;
    logic [TW-1:0] tmrCount;
    logic          tmrBusy;
    logic          tmrDone;
    logic          rdEdge;
    logic          wrEdge;
    logic          erEdge;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Decode a stored byte into the settings the core sees
    function automatic core_cfg_t cfg_from(input logic [7:0] b);
        core_cfg_t c;
        c.bootAddr             = b[`OPT_BOOT_BIT] ? `BOOT_APP_ADDR
                                                  : `BOOT_LOADER_ADDR;
        c.noiseReductionEn     = ~b[`OPT_NOISE_BIT];
        c.sixClockMachineCycle = ~b[`OPT_CYCLE_BIT];
        c.crystalLowSpeed      = ~b[`OPT_XTAL_BIT];
        c.codeReadInhibit      = ~b[`OPT_INHIBIT_BIT];
        c.lockActive           = ~b[`OPT_LOCK_BIT];
        return c;
    endfunction : cfg_from

    // Programming can only pull ones to zero; reserved bits stay one
    function automatic logic [7:0] prog_bits(input logic [7:0] old, input logic [7:0] d);
        return old & (d | `OPT_FORCED_ONES);
    endfunction : prog_bits

    // ****************************************************************
    // Operation timer
    // ****************************************************************
    flash_op_timer #(
        .TW (TW)
    ) u_timer (
        .mclk      (mclk),
        .rst       (rst),
        .clkEn     (clkEn),
        .start     (tmrStart),
        .loadCount (tmrCount),
        .busy      (tmrBusy),
        .done      (tmrDone)
    );

    // Strobe edges, taken only from the second synchroniser stage
    assign rdEdge = s_reg.sync2.rd & ~s_reg.rdD;
    assign wrEdge = s_reg.sync2.wr & ~s_reg.wrD;
    assign erEdge = s_reg.sync2.erase & ~s_reg.erD;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_next            = s_reg;
        tmrStart          = 1'b0;
        tmrCount          = '0;
        s_next.sync1      = progPins;
        s_next.sync2      = s_reg.sync1;
        s_next.rdD        = s_reg.sync2.rd;
        s_next.wrD        = s_reg.sync2.wr;
        s_next.erD        = s_reg.sync2.erase;
        s_next.refused    = 1'b0;
        s_next.arrayReq   = 1'b0;
        s_next.arrayWe    = 1'b0;
        s_next.arrayErase = 1'b0;
        case (s_reg.st)
            // Keep sampling the stored byte for as long as reset is held
            ST_LOAD: begin
                s_next.optLatch = s_reg.optStore;
                s_next.cfg      = cfg_from(s_reg.optStore);
                s_next.coreHold = 1'b1;
                if (s_reg.sync2.flashMode) begin
                    s_next.st = ST_FLASH;
                end else if (!s_reg.sync2.extReset) begin
                    s_next.st       = ST_RUN;
                    s_next.coreHold = 1'b0;
                end
            end
            // Normal operation: any programmer strobe is turned away
            ST_RUN: begin
                if (s_reg.sync2.flashMode || s_reg.sync2.extReset) begin
                    s_next.st       = ST_LOAD;
                    s_next.coreHold = 1'b1;
                end else if (rdEdge || wrEdge || erEdge) begin
                    s_next.refused = 1'b1;
                end
            end
            ST_FLASH: begin
                s_next.coreHold = 1'b1;
                if (tmrDone) begin
                    case (s_reg.pendOp)
                        OP_OPT_RD: s_next.dataOut  = s_reg.optStore;
                        OP_OPT_WR: s_next.optStore = prog_bits(s_reg.optStore,
                                                               s_reg.pendData);
                        OP_ERASE:  s_next.optStore = `OPT_ERASED;
                        OP_ARR_RD: s_next.dataOut  = arrayRdData;
                        default:   s_next.dataOut  = s_reg.dataOut;
                    endcase
                    s_next.pendOp = OP_NONE;
                end else if (!s_reg.sync2.flashMode && !tmrBusy) begin
                    s_next.st = ST_LOAD;
                end else if ((rdEdge || wrEdge || erEdge) && !tmrBusy) begin
                    if (erEdge) begin
                        // Erase-all stays possible on a locked part
                        s_next.pendOp     = OP_ERASE;
                        s_next.arrayErase = 1'b1;
                        tmrStart          = 1'b1;
                        tmrCount          = TW'(ERASE_CYCLES);
                    end else if (!s_reg.optStore[`OPT_LOCK_BIT]) begin
                        s_next.refused = 1'b1;
                        s_next.dataOut = `OPT_ERASED;
                    end else begin
                        tmrStart        = 1'b1;
                        tmrCount        = wrEdge && !rdEdge ? TW'(PROGRAM_CYCLES)
                                                            : TW'(`READ_CYCLES);
                        s_next.pendData = s_reg.sync2.data;
                        if (s_reg.sync2.addr == `OPT_BYTE_ADDR) begin
                            s_next.pendOp = rdEdge ? OP_OPT_RD : OP_OPT_WR;
                        end else begin
                            s_next.pendOp    = rdEdge ? OP_ARR_RD : OP_ARR_WR;
                            s_next.arrayReq  = 1'b1;
                            s_next.arrayWe   = ~rdEdge;
                            s_next.arrayAddr = s_reg.sync2.addr;
                            s_next.arrayData = s_reg.sync2.data;
                        end
                    end
                end
            end
            default: begin
                s_next.st = ST_LOAD;
            end
        endcase
        // Data pins drive only while the programmer reads in flash mode
        s_next.dataOe          = (s_next.st == ST_FLASH) && s_reg.sync2.rd;
        // Table reads: only the external-fetch, internal-target case is stopped
        s_next.codeReadBlocked = codeReadReq && codeReadTargetInternal
                                 && !codeReadFromInternal
                                 && !s_reg.optLatch[`OPT_INHIBIT_BIT];
        s_next.codeReadGrant   = codeReadReq && !s_next.codeReadBlocked;
    end

    // Reset puts the part in the erased, unlocked state and starts a load
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_reg          <= '0;
            s_reg.optStore <= `OPT_ERASED;
            s_reg.optLatch <= `OPT_ERASED;
            s_reg.coreHold <= 1'b1;
            // Chain starts as if external reset were held, so LOAD waits for real pins
            s_reg.sync1.extReset <= 1'b1;
            s_reg.sync2.extReset <= 1'b1;
        end else if (clkEn) begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign coreCfg         = s_reg.cfg;
    assign coreHold        = s_reg.coreHold;
    assign progDataOut     = s_reg.dataOut;
    assign progDataOe      = s_reg.dataOe;
    assign accessRefused   = s_reg.refused;
    assign flashBusy       = tmrBusy;
    assign arrayReq        = s_reg.arrayReq;
    assign arrayWe         = s_reg.arrayWe;
    assign arrayErase      = s_reg.arrayErase;
    assign arrayAddr       = s_reg.arrayAddr;
    assign arrayData       = s_reg.arrayData;
    assign codeReadGrant   = s_reg.codeReadGrant;
    assign codeReadBlocked = s_reg.codeReadBlocked;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk iff clkEn);
    endclocking
    default disable iff (rst);

    sequence seqLockedStrobe;
        s_reg.st == ST_FLASH && !tmrBusy && !tmrDone && s_reg.sync2.flashMode
        && (rdEdge || wrEdge) && !erEdge && !s_reg.optStore[`OPT_LOCK_BIT];
    endsequence

    sequence seqOptReadDone;
        tmrDone && s_reg.st == ST_FLASH && s_reg.pendOp == OP_OPT_RD;
    endsequence

    chk_normal_refuse: assert property (
        s_reg.st == ST_RUN |=> !s_reg.arrayReq && !s_reg.arrayErase && $stable(s_reg.optStore))
        else $error("flash access taken in normal mode");

    chk_top_addr_read: assert property (
        seqOptReadDone |=> progDataOut == $past(s_reg.optStore))
        else $error("option byte read returned wrong value");

    chk_bits_sticky: assert property (
        !(tmrDone && s_reg.pendOp == OP_ERASE) |=> (s_reg.optStore & ~$past(s_reg.optStore)) == 8'h00)
        else $error("programmed option bit returned to one");

    chk_lock_blocks: assert property (
        seqLockedStrobe |=> accessRefused && !arrayReq ##1 !flashBusy)
        else $error("locked part accepted an access");

    chk_inhibit_ext: assert property (
        codeReadReq && codeReadTargetInternal && !codeReadFromInternal
        && !s_reg.optLatch[`OPT_INHIBIT_BIT] |=> codeReadBlocked && !codeReadGrant)
        else $error("external table read reached internal memory");

    chk_internal_free: assert property (
        codeReadReq && (codeReadFromInternal || s_reg.optLatch[`OPT_INHIBIT_BIT])
        |=> codeReadGrant && !codeReadBlocked)
        else $error("unrestricted table read was blocked");

    chk_boot_vector: assert property (
        s_reg.st == ST_RUN |-> coreCfg.bootAddr == (s_reg.optLatch[`OPT_BOOT_BIT]
                               ? `BOOT_APP_ADDR : `BOOT_LOADER_ADDR))
        else $error("boot vector disagrees with latched setting");

    chk_core_modes: assert property (
        s_reg.st == ST_RUN |-> coreCfg.noiseReductionEn == !s_reg.optLatch[`OPT_NOISE_BIT]
                               && coreCfg.sixClockMachineCycle == !s_reg.optLatch[`OPT_CYCLE_BIT])
        else $error("core mode outputs disagree with latched setting");

    chk_latch_hold: assert property (
        s_reg.st == ST_RUN ##1 s_reg.st != ST_LOAD |-> $stable(s_reg.optLatch) && $stable(coreCfg))
        else $error("latched settings changed outside reset");

endmodule : option_byte_security_boot

// ### verif/flash_programmer_model.sv
`timescale 1ns/10ps

module flash_programmer_model (
    input  wire logic                  mclk,
    output option_byte_pkg::prog_pins_t progPins,
    input  wire logic [7:0]            progDataOut,
    input  wire logic                  progDataOe,
    input  wire logic                  accessRefused,
    input  wire logic                  flashBusy
);
    import option_byte_pkg::*;

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    // Idle pins: no mode, no strobe, bus lines parked
    initial begin
        progPins = '0;
    end

    // Mode pin changes off the sampling edge
    task automatic setMode(input logic m);
        @(negedge mclk);
        progPins.flashMode = m;
    endtask : setMode

    // External reset pin, also changed off the sampling edge
    task automatic setReset(input logic r);
        @(negedge mclk);
        progPins.extReset = r;
    endtask : setReset

    // One strobe k = {rd, wr, erase}, held until busy ends or a refusal
    task automatic doOp(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic refused);
        int n;
        @(negedge mclk);
        progPins.addr = a;
        progPins.data = d;
        {progPins.rd, progPins.wr, progPins.erase} = k;
        n = 0;
        refused = 1'b0;
        // Refusal pulse lasts one cycle, so look after every edge
        while (!flashBusy && !refused && n < 20) begin
            @(posedge mclk);
            #1;
            refused = accessRefused;
            n++;
        end
        n = 0;
        while (flashBusy && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
        end
        repeat (2) @(posedge mclk);
        #1;
        q = progDataOut;
        @(negedge mclk);
        {progPins.rd, progPins.wr, progPins.erase} = 3'h0;
        // Released bus lines do not keep the old value
        progPins.addr = ~a;
        progPins.data = ~d;
        repeat (4) @(negedge mclk);
    endtask : doOp
endmodule : flash_programmer_model

// ### verif/test_option_byte_security_boot.sv
`timescale 1ns/10ps
`include "option_byte_consts.svh"

module test_option_byte_security_boot;
    import option_byte_pkg::*;

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic mclk, rst, clkEn, codeReadReq, codeReadFromInternal, codeReadTargetInternal;
    logic arrayReq, arrayWe, arrayErase, codeReadGrant, codeReadBlocked, coreHold;
    logic progDataOe, accessRefused, flashBusy, refd, blk;
    logic [7:0] arrayRdData, progDataOut, arrayData, q, v, expByte;
    logic [15:0] arrayAddr, a;
    prog_pins_t progPins;
    core_cfg_t  coreCfg;
    int n_mismatch, check_count, cycleCount, oeCycles, erasePulses;
    integer seed;
    logic [8:0] lastArrWr;

    option_byte_security_boot #(.PROGRAM_CYCLES(30), .ERASE_CYCLES(50)) i_dut (
        .mclk(mclk), .rst(rst), .clkEn(clkEn), .progPins(progPins),
        .arrayRdData(arrayRdData), .codeReadReq(codeReadReq),
        .codeReadFromInternal(codeReadFromInternal),
        .codeReadTargetInternal(codeReadTargetInternal), .coreCfg(coreCfg),
        .coreHold(coreHold), .progDataOut(progDataOut), .progDataOe(progDataOe),
        .accessRefused(accessRefused), .flashBusy(flashBusy), .arrayReq(arrayReq),
        .arrayWe(arrayWe), .arrayErase(arrayErase), .arrayAddr(arrayAddr),
        .arrayData(arrayData), .codeReadGrant(codeReadGrant),
        .codeReadBlocked(codeReadBlocked));

    flash_programmer_model i_prog (
        .mclk(mclk), .progPins(progPins), .progDataOut(progDataOut),
        .progDataOe(progDataOe), .accessRefused(accessRefused), .flashBusy(flashBusy));

    // ****************************************************************
    // Clock, watchdog and reporting
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Whole run needs under a thousand cycles; a hang is cut well beyond that
    always @(posedge mclk) begin
        cycleCount++;
        if (cycleCount == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    // Pulse and enable monitors, taken like a flop so one-cycle pulses are not missed
    always @(posedge mclk) begin
        if (progDataOe)
            oeCycles <= oeCycles + 1;
        if (arrayErase)
            erasePulses <= erasePulses + 1;
        if (arrayReq)
            lastArrWr <= {arrayWe, arrayData};
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    // Settings the core should see for a given option byte
    function automatic core_cfg_t decode(input logic [7:0] b);
        core_cfg_t c;
        c.bootAddr = b[`OPT_BOOT_BIT] ? `BOOT_APP_ADDR : `BOOT_LOADER_ADDR;
        c.noiseReductionEn     = ~b[`OPT_NOISE_BIT];
        c.sixClockMachineCycle = ~b[`OPT_CYCLE_BIT];
        c.crystalLowSpeed      = ~b[`OPT_XTAL_BIT];
        c.codeReadInhibit      = ~b[`OPT_INHIBIT_BIT];
        c.lockActive           = ~b[`OPT_LOCK_BIT];
        return c;
    endfunction : decode

    task automatic op(input logic [2:0] k, input logic [15:0] ad, input logic [7:0] d);
        i_prog.doOp(k, ad, d, q, refd);
    endtask : op

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        seed = 32'hfc94;
        rst = 1'b1;
        clkEn = 1'b1;
        {codeReadReq, codeReadFromInternal, codeReadTargetInternal} = 3'h0;
        arrayRdData = 8'h00;
        repeat (4) @(negedge mclk);
        chk(32'(coreCfg), 32'h0);
        chk(32'(coreHold), 32'h1);
        rst = 1'b0;
        repeat (8) @(negedge mclk);
        chk(32'(coreCfg), 32'(decode(`OPT_ERASED)));
        chk(32'(coreHold), 32'h0);
        op(3'b100, `OPT_BYTE_ADDR, 8'h00);
        chk(32'(refd), 32'h1);
        chk(oeCycles, 0);
        i_prog.setMode(1'b1);
        repeat (8) @(negedge mclk);
        chk(32'(coreHold), 32'h1);
        op(3'b100, `OPT_BYTE_ADDR, 8'h00);
        chk(32'({refd, q}), 32'h0FF);
        chk(32'(oeCycles != 0), 32'h1);
        // Array read at a random address other than the option byte
        arrayRdData = 8'($random(seed));
        a = 16'($random(seed)) & 16'h7FFF;
        op(3'b100, a, 8'h00);
        chk(32'(q), 32'(arrayRdData));
        chk(32'(arrayAddr), 32'(a));
        chk(32'(lastArrWr), 32'h000);
        // Array write at the same address carries the programmer's data
        op(3'b010, a, ~arrayRdData);
        chk(32'(lastArrWr), 32'({1'b1, ~arrayRdData}));
        // Two programs, then a program of all ones but the crystal bit that must not undo zeros
        expByte = `OPT_ERASED;
        for (int k = 0; k < 3; k++) begin
            v = (k == 2) ? 8'hFF : 8'($random(seed));
            v[`OPT_LOCK_BIT] = 1'b1;
            v[`OPT_XTAL_BIT] = 1'b0;
            if (k == 1)
                v[`OPT_INHIBIT_BIT] = 1'b0;
            op(3'b010, `OPT_BYTE_ADDR, v);
            expByte = expByte & (v | `OPT_FORCED_ONES);
            op(3'b100, `OPT_BYTE_ADDR, 8'h00);
            chk(32'(q), 32'(expByte));
        end
        i_prog.setMode(1'b0);
        repeat (8) @(negedge mclk);
        chk(32'(coreCfg), 32'(decode(expByte)));
        // Random table reads under an active inhibit
        for (int i = 0; i < 40; i++) begin
            @(negedge mclk);
            if (codeReadReq) begin
                blk = codeReadTargetInternal & ~codeReadFromInternal & ~expByte[1];
                chk(32'({codeReadBlocked, codeReadGrant}), 32'({blk, ~blk}));
            end
            {codeReadReq, codeReadFromInternal, codeReadTargetInternal} = 3'($random(seed));
        end
        chk(32'(coreCfg), 32'(decode(expByte)));
        // External reset holds the core and relatches the same settings
        i_prog.setReset(1'b1);
        repeat (8) @(negedge mclk);
        chk(32'(coreHold), 32'h1);
        i_prog.setReset(1'b0);
        repeat (8) @(negedge mclk);
        chk(32'({coreHold, coreCfg}), 32'({1'b0, decode(expByte)}));
        // Erase restores ones; lock only after the byte was verified
        i_prog.setMode(1'b1);
        repeat (8) @(negedge mclk);
        op(3'b001, `OPT_BYTE_ADDR, 8'h00);
        op(3'b100, `OPT_BYTE_ADDR, 8'h00);
        chk(32'(q), 32'h0FF);
        chk(erasePulses, 1);
        op(3'b010, `OPT_BYTE_ADDR, 8'hFE);
        op(3'b100, `OPT_BYTE_ADDR, 8'h00);
        chk(32'({refd, q}), 32'h1FF);
        op(3'b100, a, 8'h00);
        chk(32'(refd), 32'h1);
        op(3'b001, `OPT_BYTE_ADDR, 8'h00);
        op(3'b100, `OPT_BYTE_ADDR, 8'h00);
        chk(32'({refd, q}), 32'h0FF);
        chk(erasePulses, 2);
        test_done();
    end
endmodule : test_option_byte_security_boot
